// File: include/cdcfg_cfg.svh
// Offsets, field positions, reset values and page codes of the converter configuration registers
`ifndef CDCFG_CFG_SVH
`define CDCFG_CFG_SVH

`define CDCFG_PAGE_OFFS_A     24'h610000
`define CDCFG_PAGE_OFFS_B     24'h610100
`define CDCFG_PAGE_GAIN_A     24'h610005
`define CDCFG_PAGE_GAIN_B     24'h610105
`define CDCFG_PAGE_MAIN_A     24'h680000
`define CDCFG_PAGE_MAIN_B     24'h680001

`define CDCFG_OFS_CORE_RST    8'h00
`define CDCFG_OFS_OFFSET_CTL  8'h68
`define CDCFG_OFS_BAND_ZONE   8'hA2
`define CDCFG_OFS_GAIN        8'hA6
`define CDCFG_OFS_PAGE        8'hFF

`define CDCFG_BIT_FREEZE      7
`define CDCFG_BIT_REQ1_HI     5
`define CDCFG_BIT_DISABLE     2
`define CDCFG_BIT_REQ1_LO     1
`define CDCFG_OFFSET_MASK     8'hA6
`define CDCFG_BIT_CORE_RST    0
`define CDCFG_BIT_ZONE_EN     3
`define CDCFG_ZONE_MASK       8'h0F
`define CDCFG_GAIN_MASK       8'h0F
`define CDCFG_GAIN_MAX        4'hB

`define CDCFG_RST_VALUE       8'h00
`define CDCFG_HOLD_RUN        3'h3
`define CDCFG_HOLD_FROZEN     3'h7

`endif

// File: include/cdcfg_pkg.sv
// Types shared by the converter configuration register bank
package cdcfg_pkg;
  typedef enum logic [2:0] {
    CDCFG_PG_NONE,
    CDCFG_PG_OFFS,
    CDCFG_PG_GAIN,
    CDCFG_PG_MAIN_A,
    CDCFG_PG_MAIN_B
  } cdcfg_page_t;

  typedef enum logic {
    CDCFG_CR_IDLE,
    CDCFG_CR_HIGH
  } cdcfg_core_rst_t;
endpackage

// File: rtl/cdcfg_chan.sv
// One channel's offset corrector control and pre-downconverter gain registers
`include "cdcfg_cfg.svh"

module cdcfg_chan (
  input  wire logic       clk_in,          // 100 MHz clock
  input  wire logic       rst_n_in,        // Async reset, active low
  input  wire logic       offs_wr_in,      // Write offset control
  input  wire logic       gain_wr_in,      // Write gain
  input  wire logic [7:0] wdata_in,        // Write data
  output logic      [7:0] offs_reg_out,    // Offset control readback
  output logic      [7:0] gain_reg_out,    // Gain readback
  output logic            ofs_freeze_out,  // Estimation held
  output logic            ofs_bypass_out,  // Corrector bypassed
  output logic            ofs_bad_out,     // Unsupported hold code
  output logic      [3:0] gain_db_out,     // Applied gain in dB
  output logic            gain_bad_out     // Unsupported gain code
);
  logic [7:0] offs_r, offs_nxt;
  logic [7:0] gain_r, gain_nxt;
  logic [2:0] hold_code;

  always_comb begin
    offs_nxt = offs_r;
    gain_nxt = gain_r;
    if (offs_wr_in) begin
      offs_nxt = wdata_in & `CDCFG_OFFSET_MASK;
    end
    if (gain_wr_in) begin
      gain_nxt = wdata_in & `CDCFG_GAIN_MASK;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      offs_r <= `CDCFG_RST_VALUE;
      gain_r <= `CDCFG_RST_VALUE;
    end else begin
      offs_r <= offs_nxt;
      gain_r <= gain_nxt;
    end
  end

  assign hold_code = {offs_r[`CDCFG_BIT_FREEZE], offs_r[`CDCFG_BIT_REQ1_HI], offs_r[`CDCFG_BIT_REQ1_LO]};

  always_comb begin
    offs_reg_out   = offs_r;
    gain_reg_out   = gain_r;
    ofs_freeze_out = (hold_code == `CDCFG_HOLD_FROZEN);
    ofs_bad_out    = (hold_code != `CDCFG_HOLD_FROZEN) && (hold_code != `CDCFG_HOLD_RUN);
    ofs_bypass_out = offs_r[`CDCFG_BIT_DISABLE];
    gain_bad_out   = (gain_r[3:0] > `CDCFG_GAIN_MAX);
    // Unsupported codes apply no gain rather than an undefined scale
    gain_db_out    = gain_bad_out ? 4'h0 : gain_r[3:0];
  end
endmodule

// File: rtl/cdcfg_regs.sv
// Converter digital configuration register bank for both channels
//
// The implementer's own choice: strobed register access.
`include "cdcfg_cfg.svh"

module cdcfg_regs (
  input  wire logic        clk_in,             // 100 MHz clock
  input  wire logic        rst_n_in,           // Async reset, active low
  input  wire logic [7:0]  addr_in,            // Register offset within page
  input  wire logic [7:0]  wdata_in,           // Write data
  input  wire logic        wr_in,              // Write strobe
  input  wire logic        rd_in,              // Read strobe
  output logic      [7:0]  rdata_out,          // Read data, cycle after rd_in
  output logic      [23:0] page_out,           // Selected page
  output logic             core_reset_out,     // Digital core reset pulse, both channels
  output logic             zone_en_a_out,      // Applied zone enable, channel A
  output logic      [2:0]  zone_a_out,         // Applied zone, channel A
  output logic             zone_en_b_out,      // Applied zone enable, channel B
  output logic      [2:0]  zone_b_out,         // Applied zone, channel B
  output logic      [1:0]  ofs_freeze_out,     // Estimation held, per channel
  output logic      [1:0]  ofs_bypass_out,     // Corrector bypassed, per channel
  output logic      [1:0]  ofs_bad_out,        // Unsupported hold code, per channel
  output logic      [7:0]  gain_db_out,        // Gain dB, B in [7:4], A in [3:0]
  output logic      [1:0]  gain_bad_out        // Unsupported gain code, per channel
);
  cdcfg_pkg::cdcfg_page_t     page_kind;
  cdcfg_pkg::cdcfg_core_rst_t cr_state_r, cr_state_nxt;
  logic        page_ch;
  logic [23:0] page_r, page_nxt;
  logic [7:0]  rdata_r, rdata_nxt;
  logic [7:0]  corerst_r, corerst_nxt;
  logic [7:0]  zone_a_r, zone_a_nxt, zone_b_r, zone_b_nxt;
  logic [3:0]  app_a_r, app_a_nxt, app_b_r, app_b_nxt;
  logic        core_rst_r, core_rst_nxt;
  logic [1:0]  freeze_r, bypass_r, obad_r, gbad_r;
  logic [1:0]  freeze_c, bypass_c, obad_c, gbad_c;
  logic [7:0]  gdb_r, gdb_c;
  logic [7:0]  offs_rd [2];
  logic [7:0]  gain_rd [2];
  logic        wr_pg, wr_core, wr_zone;
  logic [1:0]  offs_wr, gain_wr;

  // Page decode: channel pages are told apart by the page code alone
  always_comb begin
    page_kind = cdcfg_pkg::CDCFG_PG_NONE;
    page_ch   = 1'b0;
    unique case (page_r)
      `CDCFG_PAGE_OFFS_A: page_kind = cdcfg_pkg::CDCFG_PG_OFFS;
      `CDCFG_PAGE_OFFS_B: begin
        page_kind = cdcfg_pkg::CDCFG_PG_OFFS;
        page_ch   = 1'b1;
      end
      `CDCFG_PAGE_GAIN_A: page_kind = cdcfg_pkg::CDCFG_PG_GAIN;
      `CDCFG_PAGE_GAIN_B: begin
        page_kind = cdcfg_pkg::CDCFG_PG_GAIN;
        page_ch   = 1'b1;
      end
      `CDCFG_PAGE_MAIN_A: page_kind = cdcfg_pkg::CDCFG_PG_MAIN_A;
      `CDCFG_PAGE_MAIN_B: page_kind = cdcfg_pkg::CDCFG_PG_MAIN_B;
      default: page_kind = cdcfg_pkg::CDCFG_PG_NONE;
    endcase
  end

  always_comb begin
    wr_pg   = wr_in && (addr_in == `CDCFG_OFS_PAGE);
    wr_core = wr_in && (addr_in == `CDCFG_OFS_CORE_RST)
              && ((page_kind == cdcfg_pkg::CDCFG_PG_MAIN_A) || (page_kind == cdcfg_pkg::CDCFG_PG_MAIN_B));
    wr_zone = wr_in && (addr_in == `CDCFG_OFS_BAND_ZONE)
              && ((page_kind == cdcfg_pkg::CDCFG_PG_MAIN_A) || (page_kind == cdcfg_pkg::CDCFG_PG_MAIN_B));
    offs_wr = 2'h0;
    gain_wr = 2'h0;
    if (wr_in && (addr_in == `CDCFG_OFS_OFFSET_CTL) && (page_kind == cdcfg_pkg::CDCFG_PG_OFFS)) begin
      offs_wr[page_ch] = 1'b1;
    end
    if (wr_in && (addr_in == `CDCFG_OFS_GAIN) && (page_kind == cdcfg_pkg::CDCFG_PG_GAIN)) begin
      gain_wr[page_ch] = 1'b1;
    end
  end

  generate
    for (genvar ch = 0; ch < 2; ch++) begin : g_chan
      cdcfg_chan u_chan (
        .clk_in         (clk_in),
        .rst_n_in       (rst_n_in),
        .offs_wr_in     (offs_wr[ch]),
        .gain_wr_in     (gain_wr[ch]),
        .wdata_in       (wdata_in),
        .offs_reg_out   (offs_rd[ch]),
        .gain_reg_out   (gain_rd[ch]),
        .ofs_freeze_out (freeze_c[ch]),
        .ofs_bypass_out (bypass_c[ch]),
        .ofs_bad_out    (obad_c[ch]),
        .gain_db_out    (gdb_c[4*ch +: 4]),
        .gain_bad_out   (gbad_c[ch])
      );
    end
  endgenerate

  // Page select is three bytes written low first through one window register
  always_comb begin
    page_nxt = page_r;
    if (wr_pg) begin
      page_nxt = {wdata_in, page_r[23:8]};
    end
  end

  // Register file writes; the core reset bit is shared by both main pages
  always_comb begin
    corerst_nxt = corerst_r;
    zone_a_nxt  = zone_a_r;
    zone_b_nxt  = zone_b_r;
    if (wr_core) begin
      corerst_nxt = wdata_in & 8'h01;
    end
    if (wr_zone && (page_kind == cdcfg_pkg::CDCFG_PG_MAIN_A)) begin
      zone_a_nxt = wdata_in & `CDCFG_ZONE_MASK;
    end
    if (wr_zone && (page_kind == cdcfg_pkg::CDCFG_PG_MAIN_B)) begin
      zone_b_nxt = wdata_in & `CDCFG_ZONE_MASK;
    end
  end

  // Reset pulse detection: a 0 to 1 write raises the pulse, which holds until the 1 to 0 write drops it
  always_comb begin
    cr_state_nxt = cr_state_r;
    core_rst_nxt = 1'b0;
    app_a_nxt    = app_a_r;
    app_b_nxt    = app_b_r;
    unique case (cr_state_r)
      cdcfg_pkg::CDCFG_CR_IDLE: begin
        if (corerst_r[`CDCFG_BIT_CORE_RST]) begin
          cr_state_nxt = cdcfg_pkg::CDCFG_CR_HIGH;
          core_rst_nxt = 1'b1;
        end
      end
      cdcfg_pkg::CDCFG_CR_HIGH: begin
        core_rst_nxt = 1'b1;
        if (!corerst_r[`CDCFG_BIT_CORE_RST]) begin
          cr_state_nxt = cdcfg_pkg::CDCFG_CR_IDLE;
          // Zones land on the edge the reset drops, so the core never sees half-applied zones
          core_rst_nxt = 1'b0;
          // Zone code only counts when its enable was latched with it
          app_a_nxt    = zone_a_r[`CDCFG_BIT_ZONE_EN] ? zone_a_r[3:0] : 4'h0;
          app_b_nxt    = zone_b_r[`CDCFG_BIT_ZONE_EN] ? zone_b_r[3:0] : 4'h0;
        end
      end
    endcase
  end

  always_comb begin
    rdata_nxt = 8'h00;
    if (rd_in) begin
      unique case (addr_in)
        `CDCFG_OFS_PAGE: rdata_nxt = page_r[7:0];
        `CDCFG_OFS_CORE_RST: begin
          if (page_kind == cdcfg_pkg::CDCFG_PG_MAIN_A || page_kind == cdcfg_pkg::CDCFG_PG_MAIN_B) begin
            rdata_nxt = corerst_r;
          end
        end
        `CDCFG_OFS_BAND_ZONE: begin
          if (page_kind == cdcfg_pkg::CDCFG_PG_MAIN_A) begin
            rdata_nxt = zone_a_r;
          end else if (page_kind == cdcfg_pkg::CDCFG_PG_MAIN_B) begin
            rdata_nxt = zone_b_r;
          end
        end
        `CDCFG_OFS_OFFSET_CTL: begin
          if (page_kind == cdcfg_pkg::CDCFG_PG_OFFS) begin
            rdata_nxt = offs_rd[page_ch];
          end
        end
        `CDCFG_OFS_GAIN: begin
          if (page_kind == cdcfg_pkg::CDCFG_PG_GAIN) begin
            rdata_nxt = gain_rd[page_ch];
          end
        end
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      page_r     <= 24'h000000;
      rdata_r    <= 8'h00;
      corerst_r  <= `CDCFG_RST_VALUE;
      zone_a_r   <= `CDCFG_RST_VALUE;
      zone_b_r   <= `CDCFG_RST_VALUE;
      app_a_r    <= 4'h0;
      app_b_r    <= 4'h0;
      cr_state_r <= cdcfg_pkg::CDCFG_CR_IDLE;
      core_rst_r <= 1'b0;
      freeze_r   <= 2'h0;
      bypass_r   <= 2'h0;
      obad_r     <= 2'h0;
      gbad_r     <= 2'h0;
      gdb_r      <= 8'h00;
    end else begin
      page_r     <= page_nxt;
      rdata_r    <= rdata_nxt;
      corerst_r  <= corerst_nxt;
      zone_a_r   <= zone_a_nxt;
      zone_b_r   <= zone_b_nxt;
      app_a_r    <= app_a_nxt;
      app_b_r    <= app_b_nxt;
      cr_state_r <= cr_state_nxt;
      core_rst_r <= core_rst_nxt;
      freeze_r   <= freeze_c;
      bypass_r   <= bypass_c;
      obad_r     <= obad_c;
      gbad_r     <= gbad_c;
      gdb_r      <= gdb_c;
    end
  end

  assign rdata_out      = rdata_r;
  assign page_out       = page_r;
  assign core_reset_out = core_rst_r;
  assign zone_en_a_out  = app_a_r[`CDCFG_BIT_ZONE_EN];
  assign zone_a_out     = app_a_r[2:0];
  assign zone_en_b_out  = app_b_r[`CDCFG_BIT_ZONE_EN];
  assign zone_b_out     = app_b_r[2:0];
  assign ofs_freeze_out = freeze_r;
  assign ofs_bypass_out = bypass_r;
  assign ofs_bad_out    = obad_r;
  assign gain_db_out    = gdb_r;
  assign gain_bad_out   = gbad_r;
endmodule

// File: sim/cdcfg_regs_sva.sv
// Port-level assertions for the converter configuration register bank
module cdcfg_regs_sva (
  input wire logic        clk_in,         // Clock
  input wire logic        rst_n_in,       // Reset, active low
  input wire logic [7:0]  addr_in,        // Offset
  input wire logic [7:0]  wdata_in,       // Write data
  input wire logic        wr_in,          // Write strobe
  input wire logic        rd_in,          // Read strobe
  input wire logic [7:0]  rdata_out,      // Read data
  input wire logic [23:0] page_out,       // Page
  input wire logic        core_reset_out, // Core reset
  input wire logic        zone_en_a_out,  // Zone enable A
  input wire logic [2:0]  zone_a_out,     // Zone A
  input wire logic        zone_en_b_out,  // Zone enable B
  input wire logic [2:0]  zone_b_out,     // Zone B
  input wire logic [1:0]  ofs_freeze_out, // Frozen
  input wire logic [1:0]  ofs_bad_out,    // Bad hold code
  input wire logic [7:0]  gain_db_out,    // Gain
  input wire logic [1:0]  gain_bad_out    // Bad gain
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  rdata_idle_a: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
    else $error("read data outside read cycle");
  offs_resv_a: assert property ($past(rd_in && addr_in == 8'h68) |-> (rdata_out & 8'h59) == 8'h00)
    else $error("offset reserved bits not zero");
  nibble_resv_a: assert property ($past(rd_in && (addr_in == 8'hA2 || addr_in == 8'hA6))
    |-> rdata_out[7:4] == 4'h0) else $error("upper nibble not zero");
  page_shift_a: assert property ($past(wr_in && addr_in == 8'hFF)
    |-> page_out == {$past(wdata_in), $past(page_out[23:8])}) else $error("page shift wrong");
  page_hold_a: assert property (!$past(wr_in && addr_in == 8'hFF) |-> $stable(page_out))
    else $error("page changed without write");
  core_rst_cause_a: assert property ($rose(core_reset_out)
    |-> $past(wr_in && addr_in == 8'h00 && wdata_in[0], 2)) else $error("core reset without write");
  zone_latch_a: assert property (!$fell(core_reset_out)
    |-> $stable({zone_en_a_out, zone_a_out, zone_en_b_out, zone_b_out})) else $error("zone moved early");
  zone_gate_a: assert property ((zone_en_a_out || zone_a_out == 3'h0)
    && (zone_en_b_out || zone_b_out == 3'h0)) else $error("zone without enable");
  hold_code_a: assert property ((ofs_freeze_out & ofs_bad_out) == 2'b00)
    else $error("frozen and bad together");
  gain_range_a: assert property (gain_db_out[3:0] <= 4'hB && gain_db_out[7:4] <= 4'hB
    && !(gain_bad_out[0] && gain_db_out[3:0] != 4'h0)) else $error("gain out of range");
endmodule

bind cdcfg_regs cdcfg_regs_sva u_sva (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
  .rd_in(rd_in), .rdata_out(rdata_out), .page_out(page_out), .core_reset_out(core_reset_out),
  .zone_en_a_out(zone_en_a_out), .zone_a_out(zone_a_out), .zone_en_b_out(zone_en_b_out),
  .zone_b_out(zone_b_out), .ofs_freeze_out(ofs_freeze_out), .ofs_bad_out(ofs_bad_out),
  .gain_db_out(gain_db_out), .gain_bad_out(gain_bad_out)
);

// File: sim/cdcfg_regs_test.sv
// Self-checking bench for the converter configuration register bank
`include "cdcfg_cfg.svh"

module cdcfg_regs_test;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {
    logic [23:0] pg;
    logic [7:0]  ad;
    logic [7:0]  wd;
    logic [7:0]  rb;
  } cdcfg_row_t;

  logic        clk_in, rst_n_in, wr_in, rd_in, core_reset_out;
  logic [7:0]  addr_in, wdata_in, rdata_out, gain_db_out;
  logic [23:0] page_out;
  logic        zone_en_a_out, zone_en_b_out;
  logic [2:0]  zone_a_out, zone_b_out;
  logic [1:0]  ofs_freeze_out, ofs_bypass_out, ofs_bad_out, gain_bad_out;
  int          mismatches;
  int          num_checks;
  wire logic [15:0] stat = {ofs_freeze_out, ofs_bypass_out, ofs_bad_out, gain_bad_out, gain_db_out};
  wire logic [8:0]  zst  = {core_reset_out, zone_en_a_out, zone_a_out, zone_en_b_out, zone_b_out};
  // Each of the first six rows leaves a distinct value so later rows cannot mask a stray write
  cdcfg_row_t rows [8] = '{
    '{`CDCFG_PAGE_OFFS_A, 8'h68, 8'hFF, 8'hA6}, '{`CDCFG_PAGE_OFFS_B, 8'h68, 8'h22, 8'h22},
    '{`CDCFG_PAGE_GAIN_A, 8'hA6, 8'hFB, 8'h0B}, '{`CDCFG_PAGE_GAIN_B, 8'hA6, 8'h05, 8'h05},
    '{`CDCFG_PAGE_MAIN_A, 8'hA2, 8'h01, 8'h01}, '{`CDCFG_PAGE_MAIN_B, 8'hA2, 8'hFA, 8'h0A},
    '{`CDCFG_PAGE_MAIN_B, 8'h30, 8'hFF, 8'h00}, '{`CDCFG_PAGE_OFFS_A, 8'hA6, 8'h03, 8'h00}};

  cdcfg_regs dut (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
    .rd_in(rd_in), .rdata_out(rdata_out), .page_out(page_out), .core_reset_out(core_reset_out),
    .zone_en_a_out(zone_en_a_out), .zone_a_out(zone_a_out), .zone_en_b_out(zone_en_b_out),
    .zone_b_out(zone_b_out), .ofs_freeze_out(ofs_freeze_out), .ofs_bypass_out(ofs_bypass_out),
    .ofs_bad_out(ofs_bad_out), .gain_db_out(gain_db_out), .gain_bad_out(gain_bad_out));

  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    wr_in    <= 1'b1;
    addr_in  <= a;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_in);
    rd_in   <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    chk("readback", {16'h0000, e}, {16'h0000, rdata_out});
  endtask
  // Page code goes in low byte first
  task automatic pg(input logic [23:0] p);
    wr(8'hFF, p[7:0]);
    wr(8'hFF, p[15:8]);
    wr(8'hFF, p[23:16]);
  endtask
  task automatic settle();
    repeat (2) @(posedge clk_in);
    #1;
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  initial begin
    #50000;
    mismatches++;
    end_sim();
  end
  initial begin
    rst_n_in = 1'b0;
    addr_in  = 8'h00;
    wdata_in = 8'h00;
    wr_in    = 1'b0;
    rd_in    = 1'b0;
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    settle();
    chk("status", {8'h00, 16'h0C00}, {8'h00, stat});
    foreach (rows[i]) begin
      pg(rows[i].pg);
      wr(rows[i].ad, rows[i].wd);
      rd(rows[i].ad, rows[i].rb);
    end
    rd(8'h68, 8'hA6);
    chk("status", {8'h00, 16'h505B}, {8'h00, stat});
    chk("zones", {15'h0000, 9'h000}, {15'h0000, zst});
    pg(`CDCFG_PAGE_MAIN_B);
    wr(8'h00, 8'h01);
    settle();
    chk("zones", {15'h0000, 9'h100}, {15'h0000, zst});
    wr(8'h00, 8'h00);
    settle();
    chk("zones", {15'h0000, 9'h00A}, {15'h0000, zst});
    // Enable goes in first, then the code, then a fresh pulse applies it
    pg(`CDCFG_PAGE_MAIN_A);
    wr(8'hA2, 8'h08);
    wr(8'hA2, 8'h09);
    rd(8'hA2, 8'h09);
    chk("zones", {15'h0000, 9'h00A}, {15'h0000, zst});
    wr(8'h00, 8'h01);
    wr(8'h00, 8'h00);
    settle();
    chk("zones", {15'h0000, 9'h09A}, {15'h0000, zst});
    // Unsupported codes: gain clips to 0 dB, hold code 100 flagged
    pg(`CDCFG_PAGE_GAIN_A);
    wr(8'hA6, 8'h0C);
    pg(`CDCFG_PAGE_OFFS_B);
    wr(8'h68, 8'h80);
    settle();
    chk("status", {8'h00, 16'h5950}, {8'h00, stat});
    @(posedge clk_in);
    rst_n_in <= 1'b0;
    @(posedge clk_in);
    rst_n_in <= 1'b1;
    settle();
    chk("status", {8'h00, 16'h0C00}, {8'h00, stat});
    chk("zones", {15'h0000, 9'h000}, {15'h0000, zst});
    chk("page", 24'h000000, page_out);
    pg(`CDCFG_PAGE_MAIN_A);
    rd(8'hA2, 8'h00);
    rd(8'h00, 8'h00);
    end_sim();
  end
endmodule
